// [verilog/asq_pkg.sv]
package asq_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SS_INTERVAL_NS = 8200000;
  localparam int unsigned SS_CYCLES = SS_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int unsigned S3_DELAY_NS = 60000;
  localparam int unsigned S3_DELAY_CYCLES = S3_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned DEGLITCH_NS = 2000;
  localparam int unsigned DEGLITCH_CYCLES = DEGLITCH_NS / CLK_PERIOD_NS;
  localparam int unsigned SS_STEPS = 16;
  localparam logic [1:0] WAKE_LAST_INTERVAL = 2'h2;
  localparam logic [1:0] UV_RETRY_LIMIT = 2'h3;

  // register map
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam int unsigned CTRL_KEEP_ALIVE_BIT = 0;
  localparam logic CTRL_KEEP_ALIVE_RESET = 1'b0;
  localparam int unsigned STATUS_POWER_POS = 0;
  localparam int unsigned STATUS_START_POS = 4;
  localparam int unsigned STATUS_RETRY_POS = 9;
  localparam int unsigned STATUS_RAIL12_POS = 11;
  localparam int unsigned STATUS_REQ_POS = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // decoded power state
  typedef enum logic [3:0] {
    PS_HELD = 4'h1,
    PS_ACTIVE = 4'h2,
    PS_S3 = 4'h4,
    PS_S45 = 4'h8
  } asq_power_type;

  // standby regulator start-up and retry sequence
  typedef enum logic [4:0] {
    SU_WAIT = 5'h01,
    SU_RAMP = 5'h02,
    SU_ON = 5'h04,
    SU_RETRY = 5'h08,
    SU_LATCHED = 5'h10
  } asq_start_type;
endpackage

// [verilog/asq_sequencer.sv]
module asq_sequencer #(
  parameter int unsigned SS_CYCLES = asq_pkg::SS_CYCLES,
  parameter int unsigned S3_DELAY_CYCLES = asq_pkg::S3_DELAY_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // sleep requests from chipset
  input wire logic SUSPEND_RAM_REQ_N,
  input wire logic SOFT_OFF_REQ_N,
  // supervisory comparators
  input wire logic STANDBY_POR_OK,
  input wire logic AUX_UV_DETECT,
  // gate release pin, input side is the 12V POR comparator
  input wire logic NMOS_GATE_RELEASE_OD_I,
  output logic NMOS_GATE_RELEASE_OD_O,
  output logic NMOS_GATE_RELEASE_OD_OE,
  // pmos sleep gate
  output logic PMOS_SLEEP_GATE_DRIVE_O,
  output logic PMOS_SLEEP_GATE_DRIVE_OE,
  output logic PMOS_SOFT_SINK_EN,
  // standby regulator
  output logic LDO_ENABLE,
  output logic LDO_STANDBY,
  output logic [3:0] LDO_SS_LEVEL,
  // axi4-lite write
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  localparam int unsigned STEP_CYCLES = SS_CYCLES / asq_pkg::SS_STEPS;
  logic [4:0] sync1, sync2;
  logic por_ok, srst, uv, rail12;
  logic [1:0] req_val, req_seen;
  logic req_act, req_s3, req_s45;
  asq_pkg::asq_power_type ps;
  asq_pkg::asq_start_type su;
  logic [31:0] dly_cnt, wake_cnt, su_cnt, step_cnt;
  logic [1:0] wake_ivl, retry;
  logic s3_go, wake_go, uv_armed, keep;
  logic aw_hold, w_hold, wr_fire;
  logic [3:0] aw_addr, w_strb, level;
  logic [31:0] w_data, status;
  // two flops on each of the five request and comparator pins before use
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {NMOS_GATE_RELEASE_OD_I, AUX_UV_DETECT, STANDBY_POR_OK, SOFT_OFF_REQ_N, SUSPEND_RAM_REQ_N};
      sync2 <= sync1;
    end
  end

  assign por_ok = sync2[2];
  assign srst = !por_ok;
  assign uv = sync2[3];
  assign rail12 = sync2[4];

  // a level counts only once stable for the whole deglitch window
  for (genvar i = 0; i < 2; i++) begin : g_dg
    logic cand;
    logic [15:0] cnt;
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        cand <= 1'b0;
        cnt <= 16'h0000;
        req_val[i] <= 1'b0;
        req_seen[i] <= 1'b0;
      end else if (srst) begin
        cand <= 1'b0;
        cnt <= 16'h0000;
        req_val[i] <= 1'b0;
        req_seen[i] <= 1'b0;
      end else if (sync2[i] != cand) begin
        cand <= sync2[i];
        cnt <= 16'h0000;
      end else if (cnt != 16'(asq_pkg::DEGLITCH_CYCLES - 1)) begin
        cnt <= cnt + 16'h0001;
      end else begin
        req_val[i] <= cand;
        req_seen[i] <= 1'b1;
      end
    end
  end

  // bit 0 is the S3 request, bit 1 the S5 request, both active low
  assign req_act = &req_seen && req_val[0] && req_val[1];
  assign req_s3 = &req_seen && !req_val[0] && req_val[1];
  assign req_s45 = &req_seen && !req_val[0] && !req_val[1];
  assign s3_go = req_s3 && (dly_cnt == 32'(S3_DELAY_CYCLES - 1));
  assign wake_go = req_act && rail12 && (wake_ivl == asq_pkg::WAKE_LAST_INTERVAL) &&
                   (wake_cnt == 32'(SS_CYCLES - 1));

  // power state; the S5-low S3-high pattern decodes to nothing and holds
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ps <= asq_pkg::PS_HELD;
    end else if (srst) begin
      ps <= asq_pkg::PS_HELD;
    end else begin
      case (ps)
        asq_pkg::PS_HELD: begin
          if (req_s45) ps <= asq_pkg::PS_S45;
          else if (req_s3) ps <= asq_pkg::PS_S3;
          else if (wake_go) ps <= asq_pkg::PS_ACTIVE;
        end
        asq_pkg::PS_ACTIVE: begin
          if (req_s45) ps <= asq_pkg::PS_S45;
          else if (s3_go) ps <= asq_pkg::PS_S3;
        end
        asq_pkg::PS_S3: begin
          if (req_s45) ps <= asq_pkg::PS_S45;
          else if (wake_go) ps <= asq_pkg::PS_ACTIVE;
        end
        asq_pkg::PS_S45: begin
          if (wake_go) ps <= asq_pkg::PS_ACTIVE;
        end
        default: ps <= asq_pkg::PS_HELD;
      endcase
    end
  end

  // S3 entry delay restarts whenever the request wavers
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dly_cnt <= 32'h0000_0000;
    end else if (!srst && ps == asq_pkg::PS_ACTIVE && req_s3 && !s3_go) begin
      dly_cnt <= dly_cnt + 32'h0000_0001;
    end else begin
      dly_cnt <= 32'h0000_0000;
    end
  end

  // wake count: three intervals of steady 12V POR, restarts if it drops
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wake_cnt <= 32'h0000_0000;
      wake_ivl <= 2'h0;
    end else if (srst || ps == asq_pkg::PS_ACTIVE || !req_act || !rail12) begin
      wake_cnt <= 32'h0000_0000;
      wake_ivl <= 2'h0;
    end else if (wake_cnt == 32'(SS_CYCLES - 1)) begin
      wake_cnt <= 32'h0000_0000;
      if (wake_ivl != asq_pkg::WAKE_LAST_INTERVAL) wake_ivl <= wake_ivl + 2'h1;
    end else begin
      wake_cnt <= wake_cnt + 32'h0000_0001;
    end
  end

  assign uv_armed = (su == asq_pkg::SU_ON) && (ps == asq_pkg::PS_S3 || ps == asq_pkg::PS_S45);

  // start-up and undervoltage retry sequence
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      su <= asq_pkg::SU_WAIT;
      su_cnt <= 32'h0000_0000;
      retry <= 2'h0;
    end else if (srst) begin
      su <= asq_pkg::SU_WAIT;
      su_cnt <= 32'h0000_0000;
      retry <= 2'h0;
    end else begin
      case (su)
        asq_pkg::SU_WAIT, asq_pkg::SU_RETRY, asq_pkg::SU_RAMP: begin
          if (su_cnt == 32'(SS_CYCLES - 1)) begin
            if (su == asq_pkg::SU_RAMP) su <= asq_pkg::SU_ON;
            else su <= asq_pkg::SU_RAMP;
            su_cnt <= 32'h0000_0000;
          end else begin
            su_cnt <= su_cnt + 32'h0000_0001;
          end
        end
        asq_pkg::SU_ON: begin
          if (uv_armed && uv) begin
            if (retry == asq_pkg::UV_RETRY_LIMIT) begin
              su <= asq_pkg::SU_LATCHED;
            end else begin
              su <= asq_pkg::SU_RETRY;
              retry <= retry + 2'h1;
            end
          end
        end
        asq_pkg::SU_LATCHED: su <= asq_pkg::SU_LATCHED;
        default: su <= asq_pkg::SU_WAIT;
      endcase
    end
  end

  // ramp level steps up evenly across one interval
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      step_cnt <= 32'h0000_0000;
      level <= 4'h0;
    end else if (su == asq_pkg::SU_ON) begin
      step_cnt <= 32'h0000_0000;
      level <= 4'hf;
    end else if (su != asq_pkg::SU_RAMP || srst) begin
      step_cnt <= 32'h0000_0000;
      level <= 4'h0;
    end else if (step_cnt == 32'(STEP_CYCLES - 1)) begin
      step_cnt <= 32'h0000_0000;
      if (level != 4'hf) level <= level + 4'h1;
    end else begin
      step_cnt <= step_cnt + 32'h0000_0001;
    end
  end

  // pin and regulator drives, all registered
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      NMOS_GATE_RELEASE_OD_O <= 1'b0;
      NMOS_GATE_RELEASE_OD_OE <= 1'b1;
      PMOS_SLEEP_GATE_DRIVE_O <= 1'b0;
      PMOS_SLEEP_GATE_DRIVE_OE <= 1'b0;
      PMOS_SOFT_SINK_EN <= 1'b0;
      LDO_ENABLE <= 1'b0;
      LDO_STANDBY <= 1'b0;
      LDO_SS_LEVEL <= 4'h0;
    end else begin
      NMOS_GATE_RELEASE_OD_O <= 1'b0;
      NMOS_GATE_RELEASE_OD_OE <= srst || ps != asq_pkg::PS_ACTIVE;
      PMOS_SLEEP_GATE_DRIVE_O <= 1'b0;
      // hard pull only once the regulator is up, so the gate never snaps early
      PMOS_SLEEP_GATE_DRIVE_OE <= !srst && su == asq_pkg::SU_ON &&
        (ps == asq_pkg::PS_S3 || (keep && ps == asq_pkg::PS_S45));
      PMOS_SOFT_SINK_EN <= !srst && keep && su == asq_pkg::SU_RAMP && ps != asq_pkg::PS_ACTIVE;
      LDO_ENABLE <= !srst && ps != asq_pkg::PS_ACTIVE &&
        (su == asq_pkg::SU_RAMP || su == asq_pkg::SU_ON);
      LDO_STANDBY <= !srst && ps == asq_pkg::PS_ACTIVE;
      LDO_SS_LEVEL <= level;
    end
  end

  // axi write address and data, accepted in either order
  assign wr_fire = aw_hold && w_hold && !S_AXI_BVALID;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_hold <= 1'b0;
      aw_addr <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        aw_hold <= 1'b0;
      end
      S_AXI_AWREADY <= !aw_hold && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        w_hold <= 1'b0;
      end
      S_AXI_WREADY <= !w_hold && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= asq_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= ({aw_addr[3:2], 2'h0} == asq_pkg::CTRL_OFFSET ||
        {aw_addr[3:2], 2'h0} == asq_pkg::STATUS_OFFSET) ? asq_pkg::RESP_OKAY : asq_pkg::RESP_DECERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // option bit; cleared with the rest of the block on standby loss
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      keep <= asq_pkg::CTRL_KEEP_ALIVE_RESET;
    end else if (srst) begin
      keep <= asq_pkg::CTRL_KEEP_ALIVE_RESET;
    end else if (wr_fire && {aw_addr[3:2], 2'h0} == asq_pkg::CTRL_OFFSET && w_strb[0]) begin
      keep <= w_data[asq_pkg::CTRL_KEEP_ALIVE_BIT];
    end
  end

  always_comb begin
    status = 32'h0000_0000;
    status[asq_pkg::STATUS_POWER_POS +: 4] = ps;
    status[asq_pkg::STATUS_START_POS +: 5] = su;
    status[asq_pkg::STATUS_RETRY_POS +: 2] = retry;
    status[asq_pkg::STATUS_RAIL12_POS] = rail12;
    status[asq_pkg::STATUS_REQ_POS +: 2] = req_val;
  end

  // axi read
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= asq_pkg::RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        if ({S_AXI_ARADDR[3:2], 2'h0} == asq_pkg::CTRL_OFFSET) begin
          S_AXI_RDATA <= {31'h0000_0000, keep};
          S_AXI_RRESP <= asq_pkg::RESP_OKAY;
        end else if ({S_AXI_ARADDR[3:2], 2'h0} == asq_pkg::STATUS_OFFSET) begin
          S_AXI_RDATA <= status;
          S_AXI_RRESP <= asq_pkg::RESP_OKAY;
        end else begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= asq_pkg::RESP_DECERR;
        end
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  a_od_never_high: assert property (!NMOS_GATE_RELEASE_OD_O)
    else $error("gate release pin driven high");
  a_od_low_asleep: assert property (ps != asq_pkg::PS_ACTIVE |=> NMOS_GATE_RELEASE_OD_OE)
    else $error("gate release pin floated outside active");
  a_no_s45_to_s3: assert property (ps == asq_pkg::PS_S45 |=> ps != asq_pkg::PS_S3)
    else $error("illegal S4/S5 to S3 move");
  a_wake_qualified: assert property ((ps != asq_pkg::PS_ACTIVE) ##1 (ps == asq_pkg::PS_ACTIVE)
    |-> $past(rail12) && $past(wake_ivl) == asq_pkg::WAKE_LAST_INTERVAL)
    else $error("active entered without three intervals of 12V POR");
  a_s3_delay_full: assert property ((ps == asq_pkg::PS_ACTIVE) ##1 (ps == asq_pkg::PS_S3)
    |-> $past(dly_cnt) == 32'(S3_DELAY_CYCLES - 1))
    else $error("S3 entered before delay elapsed");
  a_s45_at_once: assert property (ps == asq_pkg::PS_ACTIVE && req_s45 && por_ok |=> ps == asq_pkg::PS_S45)
    else $error("S4/S5 entry delayed");
  a_active_pmos_off: assert property (ps == asq_pkg::PS_ACTIVE && por_ok |=> !PMOS_SLEEP_GATE_DRIVE_OE)
    else $error("PMOS gate driven in active");
  a_active_ldo_stby: assert property (ps == asq_pkg::PS_ACTIVE && por_ok |=> LDO_STANDBY && !LDO_ENABLE)
    else $error("regulator not in standby in active");
  a_uv_fourth_latch: assert property (uv_armed && uv && retry == asq_pkg::UV_RETRY_LIMIT && por_ok
    |=> su == asq_pkg::SU_LATCHED)
    else $error("fourth undervoltage did not latch off");
  a_uv_ignored_awake: assert property (su == asq_pkg::SU_ON && !uv_armed
    |=> su != asq_pkg::SU_RETRY && su != asq_pkg::SU_LATCHED)
    else $error("undervoltage acted outside sleep");
  a_por_loss_reset: assert property (!por_ok |=> ps == asq_pkg::PS_HELD && su == asq_pkg::SU_WAIT)
    else $error("standby POR loss did not reset block");
  a_keep_sink_ramp: assert property (keep && su == asq_pkg::SU_RAMP && ps != asq_pkg::PS_ACTIVE && por_ok
    |=> PMOS_SOFT_SINK_EN)
    else $error("soft sink missing during ramp");

  c_enter_active: cover property ((ps != asq_pkg::PS_ACTIVE) ##1 (ps == asq_pkg::PS_ACTIVE));
  c_enter_s3: cover property ((ps == asq_pkg::PS_ACTIVE) ##1 (ps == asq_pkg::PS_S3));
  c_latched: cover property (su == asq_pkg::SU_LATCHED);
  c_keep_s45_on: cover property (keep && ps == asq_pkg::PS_S45 && PMOS_SLEEP_GATE_DRIVE_OE);
endmodule

// [testbench/asq_chipset_model.sv]
module asq_chipset_model (
  // clock
  input wire logic CORE_CLK,
  // commands from the bench: 0 active, 1 suspend, 2 soft off, 3 held combination
  input wire logic [1:0] want_state,
  input wire logic rail12_up,
  input wire logic standby_up,
  input wire logic aux_uv,
  // pins toward the sequencer
  output logic chipset_suspend_ram_n = 1'b0,
  output logic chipset_soft_off_n = 1'b0,
  output logic standby_por_ok = 1'b0,
  output logic rail12_por_ok = 1'b0,
  output logic aux_uv_detect = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // sleep outputs are active low, changed only after an edge
  always @(posedge CORE_CLK) begin
    chipset_suspend_ram_n <= (want_state == 2'h0) || (want_state == 2'h3);
    chipset_soft_off_n <= !want_state[1];
    standby_por_ok <= standby_up;
    rail12_por_ok <= rail12_up;
    aux_uv_detect <= aux_uv;
  end
endmodule

// [testbench/tb_asq_sequencer.sv]
module tb_asq_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SS = 256;
  localparam int unsigned S3D = 20;
  localparam int unsigned DG = 200;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] want_state = 2'h2;
  logic rail12_up = 1'b0;
  logic standby_up = 1'b0;
  logic aux_uv = 1'b0;
  logic s3n, s5n, sb_ok, r12_ok, uv_det;
  logic od_o, od_oe, pm_o, pm_oe, sink, ldo_en, ldo_sb;
  logic [3:0] ldo_lvl;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [3:0] wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int errors = 0;
  int checked = 0;

  initial begin
    forever #5 core_clk = !core_clk;
  end

  // the comparator reads the rail through the pull-up, not the pulled-low node
  asq_chipset_model i_asq_chipset_model (.CORE_CLK(core_clk), .want_state(want_state), .rail12_up(rail12_up),
    .standby_up(standby_up), .aux_uv(aux_uv), .chipset_suspend_ram_n(s3n), .chipset_soft_off_n(s5n),
    .standby_por_ok(sb_ok), .rail12_por_ok(r12_ok), .aux_uv_detect(uv_det));

  asq_sequencer #(.SS_CYCLES(SS), .S3_DELAY_CYCLES(S3D)) i_asq_sequencer (.CORE_CLK(core_clk),
    .RESET_N(reset_n), .SUSPEND_RAM_REQ_N(s3n), .SOFT_OFF_REQ_N(s5n), .STANDBY_POR_OK(sb_ok),
    .AUX_UV_DETECT(uv_det), .NMOS_GATE_RELEASE_OD_I(r12_ok), .NMOS_GATE_RELEASE_OD_O(od_o),
    .NMOS_GATE_RELEASE_OD_OE(od_oe), .PMOS_SLEEP_GATE_DRIVE_O(pm_o), .PMOS_SLEEP_GATE_DRIVE_OE(pm_oe),
    .PMOS_SOFT_SINK_EN(sink), .LDO_ENABLE(ldo_en), .LDO_STANDBY(ldo_sb), .LDO_SS_LEVEL(ldo_lvl),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  task chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_of_test;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    logic busy;
    n = 0;
    busy = 1'b1;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // a local flag ends the wait: bready itself only updates after this time step
    while (busy && n < 100) begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        busy = 1'b0;
      end
    end
    if (busy) begin
      errors++;
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b0;
    end
  endtask

  task axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic busy;
    n = 0;
    busy = 1'b1;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (busy && n < 100) begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        busy = 1'b0;
      end
    end
    if (busy) begin
      errors++;
      arvalid <= 1'b0;
      rready <= 1'b0;
    end
  endtask

  task chk_status(input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(asq_pkg::STATUS_OFFSET, d, r);
    chk_word(d & mask, exp);
  endtask

  initial begin
    int n;
    logic [1:0] r;
    logic [31:0] d;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk_bit(od_oe, 1'b1);
    chk_bit(ldo_en, 1'b0);
    chk_status(32'hf, 32'h1);
    // power-up into soft off, standard option
    standby_up <= 1'b1;
    for (n = 0; n < 2000 && ldo_en !== 1'b1; n++) @(posedge core_clk);
    chk_bit(n >= SS && n <= SS + 8, 1'b1);
    repeat (SS / 2) @(posedge core_clk);
    chk_bit(ldo_lvl > 4'h0 && ldo_lvl < 4'hf, 1'b1);
    repeat (SS) @(posedge core_clk);
    chk_word({28'h0, ldo_lvl}, 32'hf);
    chk_bit(pm_oe, 1'b0);
    chk_bit(ldo_en, 1'b1);
    chk_bit(od_o, 1'b0);
    chk_status(32'h1ff, 32'h048);
    // suspend request from soft off, then the held combination
    want_state <= 2'h1;
    repeat (DG + 20) @(posedge core_clk);
    chk_status(32'hf, 32'h8);
    want_state <= 2'h3;
    repeat (DG + 20) @(posedge core_clk);
    chk_status(32'hf, 32'h8);
    // wake waits for the 12V rail, then three intervals
    want_state <= 2'h0;
    repeat (DG + 3 * SS + 20) @(posedge core_clk);
    chk_bit(od_oe, 1'b1);
    rail12_up <= 1'b1;
    for (n = 0; n < 3000 && od_oe !== 1'b0; n++) @(posedge core_clk);
    chk_bit(n >= 3 * SS && n <= 3 * SS + DG + 8, 1'b1);
    chk_bit(od_oe, 1'b0);
    chk_bit(pm_oe, 1'b0);
    chk_bit(ldo_sb, 1'b1);
    chk_status(32'h80f, 32'h802);
    // undervoltage ignored while active; short suspend pulse filtered
    aux_uv <= 1'b1;
    repeat (20) @(posedge core_clk);
    aux_uv <= 1'b0;
    chk_status(32'h7f0, 32'h040);
    want_state <= 2'h1;
    repeat (DG / 2) @(posedge core_clk);
    want_state <= 2'h0;
    repeat (DG + 20) @(posedge core_clk);
    chk_bit(od_oe, 1'b0);
    // active to suspend after the entry delay
    want_state <= 2'h1;
    for (n = 0; n < 2000 && pm_oe !== 1'b1; n++) @(posedge core_clk);
    chk_bit(n >= DG + S3D && n <= DG + S3D + 8, 1'b1);
    chk_bit(od_oe, 1'b1);
    chk_bit(pm_o, 1'b0);
    repeat (4) @(posedge core_clk);
    chk_bit(ldo_en, 1'b1);
    chk_status(32'hf, 32'h4);
    // active to soft off with no entry delay
    want_state <= 2'h0;
    for (n = 0; n < 3000 && od_oe !== 1'b0; n++) @(posedge core_clk);
    want_state <= 2'h2;
    for (n = 0; n < 2000 && od_oe !== 1'b1; n++) @(posedge core_clk);
    chk_bit(n <= DG + 10, 1'b1);
    chk_bit(pm_oe, 1'b0);
    rail12_up <= 1'b0;
    // persistent undervoltage: three retries, then latched off
    repeat (10) @(posedge core_clk);
    aux_uv <= 1'b1;
    for (n = 0; n < 12 && ldo_en !== 1'b0; n++) @(posedge core_clk);
    chk_bit(ldo_en, 1'b0);
    repeat (12 * SS) @(posedge core_clk);
    chk_status(32'h7f0, 32'h700);
    aux_uv <= 1'b0;
    repeat (3 * SS) @(posedge core_clk);
    chk_bit(ldo_en, 1'b0);
    // losing standby resets the block; restart with keep-alive
    standby_up <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk_status(32'h7ff, 32'h011);
    standby_up <= 1'b1;
    repeat (6) @(posedge core_clk);
    axi_write(asq_pkg::CTRL_OFFSET, 32'h1, 4'he, r);
    axi_read(asq_pkg::CTRL_OFFSET, d, r);
    chk_word(d & 32'h1, 32'h0);
    axi_write(asq_pkg::CTRL_OFFSET, 32'h1, 4'h1, r);
    axi_read(asq_pkg::CTRL_OFFSET, d, r);
    chk_word(d & 32'h1, 32'h1);
    for (n = 0; n < 2000 && ldo_en !== 1'b1; n++) @(posedge core_clk);
    repeat (SS / 2) @(posedge core_clk);
    chk_bit(sink, 1'b1);
    chk_bit(pm_oe, 1'b0);
    repeat (SS) @(posedge core_clk);
    chk_bit(sink, 1'b0);
    chk_bit(pm_oe, 1'b1);
    // unmapped and read-only places
    axi_read(4'h8, d, r);
    chk_word({d[29:0], r}, 32'h3);
    axi_write(4'hc, 32'h1, 4'hf, r);
    chk_word({30'h0, r}, 32'h3);
    axi_write(asq_pkg::STATUS_OFFSET, 32'hffff, 4'hf, r);
    chk_word({30'h0, r}, 32'h0);
    end_of_test;
  end

  // the whole sequence needs roughly 9000 cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    end_of_test;
  end
endmodule
